// File: src/ipe_input_config.sv
// Input pin configuration: pull selection, interrupt polarity and event FIFO routing.
`timescale 1ns/100ps
module ipe_input_config
	import ipe_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Raw general input pins, asynchronous to clk.
	input  wire logic [IPE_NUM_IN-1:0]  general_input_pin,
	// Device register port.
	input  wire logic [7:0]             reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	// Column pull resistor controls, one bit per column pin.
	output logic      [IPE_NUM_COL-1:0] column_pullup_weak,
	output logic      [IPE_NUM_COL-1:0] column_pulldown,
	output logic      [IPE_NUM_COL-1:0] column_pullup_strong,
	// Aggregate input interrupt level.
	output logic                        aggregate_input_irq,
	// Entries toward the event FIFO.
	output logic                        event_valid,
	input  wire logic                   event_ready,
	output logic      [7:0]             event_code,
	output logic                        event_irq_set
);

	localparam int N = IPE_NUM_IN;
	localparam int C = IPE_NUM_COL;

	// All state of the block apart from the flag bank in one record.
	typedef struct packed {
		logic [N-1:0]   sync1;
		logic [N-1:0]   sync2;
		logic [N-1:0]   prev;
		logic [1:0]     prime;
		logic [2*C-1:0] pull;
		logic [N-1:0]   pol;
		logic [N-1:0]   route;
		logic [N-1:0]   en;
		logic [N-1:0]   pend;
		logic [7:0]     rdata;
		logic           evt_valid;
		logic [7:0]     evt_code;
		logic           evt_irq;
	} ipe_state_t;

	ipe_state_t   q;
	ipe_state_t   d;
	logic [N-1:0] flag;
	logic [N-1:0] flag_clear;
	logic         agg_irq;

	// Read strobes that clear the flag status registers.
	always_comb begin
		flag_clear = '0;
		if (reg_rd && reg_addr == IPE_OFS_FLAG_LOW) begin
			flag_clear[IPE_NUM_LOW-1:0] = '1;
		end
		if (reg_rd && reg_addr == IPE_OFS_FLAG_HIGH) begin
			flag_clear[N-1:IPE_NUM_LOW] = '1;
		end
	end

	// Flags and the aggregate interrupt sit in their own bank.
	ipe_flag_bank #(
		.N (N)
	) u_flags (
		.clk      (clk),
		.rst      (rst),
		.level    (q.sync2),
		.polarity (q.pol),
		.route    (q.route),
		.enable   (q.en),
		.clear    (flag_clear),
		.flag     (flag),
		.irq      (agg_irq)
	);

	// Next-state logic: synchroniser, register writes, reads and the event issuer.
	always_comb begin
		logic [N-1:0] activity;
		logic [N-1:0] taken;
		logic         load;
		logic         found;
		logic [6:0]   idx;
		logic         lvl;
		activity = '0;
		taken = '0;
		load = 1'b0;
		found = 1'b0;
		idx = '0;
		lvl = 1'b0;
		d = q;

		// Two flops before any logic sees a pin.
		d.sync1 = general_input_pin;
		d.sync2 = q.sync1;
		d.prev = q.sync2;

		// Hold off activity until the synchroniser carries real pin levels.
		if (q.prime != IPE_PRIME_CYCLES) begin
			d.prime = q.prime + 2'h1;
		end

		// Register writes; reserved bits are not stored.
		if (reg_wr) begin
			case (reg_addr)
				IPE_OFS_PULL_LOW: begin
					d.pull[7:0] = reg_wdata;
				end
				IPE_OFS_PULL_HIGH: begin
					d.pull[2*C-1:8] = reg_wdata[1:0];
				end
				IPE_OFS_POL_LOW: begin
					d.pol[IPE_NUM_LOW-1:0] = reg_wdata[IPE_NUM_LOW-1:0];
				end
				IPE_OFS_POL_HIGH: begin
					d.pol[N-1:IPE_NUM_LOW] = reg_wdata[IPE_NUM_HIGH-1:0];
				end
				IPE_OFS_ROUTE_LOW: begin
					d.route[IPE_NUM_LOW-1:0] = reg_wdata[IPE_NUM_LOW-1:0];
				end
				IPE_OFS_ROUTE_HIGH: begin
					d.route[N-1:IPE_NUM_LOW] = reg_wdata[IPE_NUM_HIGH-1:0];
				end
				IPE_OFS_EN_LOW: begin
					d.en[IPE_NUM_LOW-1:0] = reg_wdata[IPE_NUM_LOW-1:0];
				end
				IPE_OFS_EN_HIGH: begin
					d.en[N-1:IPE_NUM_LOW] = reg_wdata[IPE_NUM_HIGH-1:0];
				end
				default: begin
					d.pull = q.pull;
				end
			endcase
		end

		// Read data is registered; unmapped offsets and reserved bits read zero.
		d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				IPE_OFS_FLAG_LOW: begin
					d.rdata = {2'h0, flag[IPE_NUM_LOW-1:0]};
				end
				IPE_OFS_FLAG_HIGH: begin
					d.rdata = {3'h0, flag[N-1:IPE_NUM_LOW]};
				end
				IPE_OFS_LEVEL_LOW: begin
					d.rdata = {2'h0, q.sync2[IPE_NUM_LOW-1:0]};
				end
				IPE_OFS_LEVEL_HIGH: begin
					d.rdata = {3'h0, q.sync2[N-1:IPE_NUM_LOW]};
				end
				IPE_OFS_PULL_LOW: begin
					d.rdata = q.pull[7:0];
				end
				IPE_OFS_PULL_HIGH: begin
					d.rdata = {6'h00, q.pull[2*C-1:8]};
				end
				IPE_OFS_POL_LOW: begin
					d.rdata = {2'h0, q.pol[IPE_NUM_LOW-1:0]};
				end
				IPE_OFS_POL_HIGH: begin
					d.rdata = {3'h0, q.pol[N-1:IPE_NUM_LOW]};
				end
				IPE_OFS_ROUTE_LOW: begin
					d.rdata = {2'h0, q.route[IPE_NUM_LOW-1:0]};
				end
				IPE_OFS_ROUTE_HIGH: begin
					d.rdata = {3'h0, q.route[N-1:IPE_NUM_LOW]};
				end
				IPE_OFS_EN_LOW: begin
					d.rdata = {2'h0, q.en[IPE_NUM_LOW-1:0]};
				end
				IPE_OFS_EN_HIGH: begin
					d.rdata = {3'h0, q.en[N-1:IPE_NUM_LOW]};
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end

		// Any change of a routed input's level is activity for the FIFO.
		if (q.prime == IPE_PRIME_CYCLES) begin
			activity = (q.sync2 ^ q.prev) & q.route;
		end

		// The output slot is free when empty or when the FIFO takes its entry.
		load = !q.evt_valid || event_ready;
		if (q.evt_valid && event_ready) begin
			d.evt_valid = 1'b0;
		end

		// Lowest pending input goes first; its level is read when it is issued.
		if (load) begin
			for (int i = N - 1; i >= 0; i--) begin
				if (q.pend[i] && q.route[i]) begin
					found = 1'b1;
					idx = 7'(i);
					lvl = q.sync2[i];
				end
			end
			if (found) begin
				taken[idx[3:0]] = 1'b1;
				d.evt_valid = 1'b1;
				d.evt_code[IPE_EVT_LEVEL_BIT] = lvl;
				d.evt_code[6:0] = IPE_EVT_CODE_BASE + idx;
			end
		end

		// New activity wins over the issue; unrouted inputs drop what they had pending.
		d.pend = ((q.pend & ~taken) | activity) & q.route;

		// Each entry accepted by the FIFO asks for the event interrupt.
		d.evt_irq = q.evt_valid && event_ready;
	end

	// State register with reset values.
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.pull <= {IPE_PULL_HIGH_RST, IPE_PULL_LOW_RST};
			q.pol <= IPE_POL_RST;
			q.route <= IPE_ROUTE_RST;
			q.en <= IPE_EN_RST;
		end else begin
			q <= d;
		end
	end

	// Decode each column's pull field into resistor controls.
	for (genvar c = 0; c < C; c++) begin : g_col_pull
		ipe_pull_t sel;
		assign sel = ipe_pull_t'(q.pull[2*c+1:2*c]);
		assign column_pullup_weak[c]   = (sel == IPE_PULL_UP_WEAK);
		assign column_pulldown[c]      = (sel == IPE_PULL_DOWN);
		assign column_pullup_strong[c] = (sel == IPE_PULL_UP_STRONG);
	end

	// Outputs.
	assign reg_rdata           = q.rdata;
	assign aggregate_input_irq = agg_irq;
	assign event_valid         = q.evt_valid;
	assign event_code          = q.evt_code;
	assign event_irq_set       = q.evt_irq;

endmodule // ipe_input_config

// File: src/ipe_pkg.sv
// Package with the register map, reset values and encodings of the input configuration block.
// Functional notes
// - Pull field 00 weak pull-up, 01 pull-down, 10 strong pull-up, 11 all off.
// - Polarity bit 0 sets the input flag whenever the pin samples low.
// - Polarity bit 1 sets the input flag whenever the pin samples high.
// - Route bit 1 turns input activity into FIFO entries; route bit 0 gives none.
// - Activity on a routed input raises the FIFO event interrupt.
// - Routed inputs never feed the aggregate input interrupt, whatever their enable.
// - Entries from routed inputs are coded as key events usable for unlock matching.
// - Reading a flag status register clears the flags it holds whose pin has left the chosen level.
// - Aggregate interrupt needs flag set, condition met and enable bit at one.
package ipe_pkg;

	// Input counts: rows R0..R5 are inputs 0..5, columns C0..C4 are inputs 6..10.
	localparam int IPE_NUM_IN   = 11;
	localparam int IPE_NUM_LOW  = 6;
	localparam int IPE_NUM_HIGH = 5;
	localparam int IPE_NUM_COL  = 5;
	localparam int IPE_COL_BASE = 6;

	// Register offsets on the device register port.
	localparam logic [7:0] IPE_OFS_FLAG_LOW   = 8'h13;
	localparam logic [7:0] IPE_OFS_FLAG_HIGH  = 8'h14;
	localparam logic [7:0] IPE_OFS_LEVEL_LOW  = 8'h15;
	localparam logic [7:0] IPE_OFS_LEVEL_HIGH = 8'h16;
	localparam logic [7:0] IPE_OFS_PULL_LOW   = 8'h19;
	localparam logic [7:0] IPE_OFS_PULL_HIGH  = 8'h1A;
	localparam logic [7:0] IPE_OFS_POL_LOW    = 8'h1B;
	localparam logic [7:0] IPE_OFS_POL_HIGH   = 8'h1C;
	localparam logic [7:0] IPE_OFS_ROUTE_LOW  = 8'h1D;
	localparam logic [7:0] IPE_OFS_ROUTE_HIGH = 8'h1E;
	localparam logic [7:0] IPE_OFS_EN_LOW     = 8'h1F;
	localparam logic [7:0] IPE_OFS_EN_HIGH    = 8'h20;

	// Values after reset.
	localparam logic [7:0]  IPE_PULL_LOW_RST  = 8'h51;
	localparam logic [1:0]  IPE_PULL_HIGH_RST = 2'h1;
	localparam logic [10:0] IPE_POL_RST       = 11'h000;
	localparam logic [10:0] IPE_ROUTE_RST     = 11'h000;
	localparam logic [10:0] IPE_EN_RST        = 11'h000;

	// Cycles after reset before pin changes count as activity.
	localparam logic [1:0] IPE_PRIME_CYCLES = 2'h3;

	// Event entry: bit 7 is the pin level, bits 6:0 the key-style event number.
	localparam logic [6:0] IPE_EVT_CODE_BASE = 7'h25;
	localparam int         IPE_EVT_LEVEL_BIT = 7;

	// Pull selection codes of one 2-bit field.
	typedef enum logic [1:0] {
		IPE_PULL_UP_WEAK   = 2'h0,
		IPE_PULL_DOWN      = 2'h1,
		IPE_PULL_UP_STRONG = 2'h2,
		IPE_PULL_OFF       = 2'h3
	} ipe_pull_t;

endpackage

// File: src/ipe_flag_bank.sv
// Per-input level-sensitive interrupt flags and the aggregate input interrupt.
`timescale 1ns/100ps
module ipe_flag_bank
	import ipe_pkg::*;
#(
	parameter int N = 11
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] level,
	input  wire logic [N-1:0] polarity,
	input  wire logic [N-1:0] route,
	input  wire logic [N-1:0] enable,
	input  wire logic [N-1:0] clear,
	output logic      [N-1:0] flag,
	output logic              irq
);

	typedef struct packed {
		logic [N-1:0] flag;
		logic         irq;
	} ipe_flag_state_t;

	ipe_flag_state_t q;
	ipe_flag_state_t d;
	logic [N-1:0]    cond;

	// A flag is set while its pin sits at the chosen level; the set wins over a read clear.
	always_comb begin
		d = q;
		cond = ~(level ^ polarity);
		d.flag = (q.flag & ~clear) | cond;
		d.irq = |(q.flag & cond & enable & ~route);
	end

	// State register.
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign flag = q.flag;
	assign irq  = q.irq;

endmodule // ipe_flag_bank

// File: testbench/ipe_input_config_props.sv
// Checker of the input configuration block ports.
`timescale 1ns/100ps
module ipe_input_config_props
	import ipe_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic [7:0]             reg_addr,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	input wire logic [IPE_NUM_COL-1:0] column_pullup_weak,
	input wire logic [IPE_NUM_COL-1:0] column_pulldown,
	input wire logic [IPE_NUM_COL-1:0] column_pullup_strong,
	input wire logic                   aggregate_input_irq,
	input wire logic                   event_valid,
	input wire logic                   event_ready,
	input wire logic [7:0]             event_code,
	input wire logic                   event_irq_set
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// At most one resistor of a column is on at any time.
	a_pull_exclusive: assert property (!(|((column_pullup_weak & column_pulldown)
		| (column_pullup_weak & column_pullup_strong) | (column_pulldown & column_pullup_strong))))
		else $error("pull resistors overlap");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_flag_reserved: assert property (reg_rd && reg_addr == IPE_OFS_FLAG_LOW |=> !(|reg_rdata[7:6]))
		else $error("reserved flag bits set");
	a_irq_after_take: assert property (event_valid && event_ready |=> event_irq_set)
		else $error("no event interrupt");
	a_irq_cause: assert property (event_irq_set |-> $past(event_valid && event_ready))
		else $error("event interrupt without entry");
	a_entry_holds: assert property (event_valid && !event_ready |=> event_valid && $stable(event_code))
		else $error("entry dropped under stall");
	a_code_range: assert property (event_valid |-> event_code[6:0] - IPE_EVT_CODE_BASE < 7'h0B)
		else $error("event number out of range");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !aggregate_input_irq && !event_valid)
		else $error("outputs active in reset");
	c_take: cover property (event_valid && event_ready);
	c_stall: cover property (event_valid && !event_ready);
	c_irq: cover property (aggregate_input_irq);
endmodule // ipe_input_config_props

bind ipe_input_config ipe_input_config_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .column_pullup_weak(column_pullup_weak),
	.column_pulldown(column_pulldown), .column_pullup_strong(column_pullup_strong),
	.aggregate_input_irq(aggregate_input_irq), .event_valid(event_valid),
	.event_ready(event_ready), .event_code(event_code), .event_irq_set(event_irq_set));

// File: testbench/ipe_fifo_sink.sv
// Event FIFO sink model that takes entries and can stall.
`timescale 1ns/100ps
module ipe_fifo_sink (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       stall,
	input  wire logic       event_valid,
	input  wire logic [7:0] event_code,
	output logic            event_ready,
	output logic [7:0]      n_taken,
	output logic [7:0]      last_code
);
	// Ready drops for a cycle after each entry, so the source also meets a slow sink.
	always_ff @(posedge clk) begin
		if (rst) begin
			event_ready <= 1'b0;
			n_taken <= 8'h00;
			last_code <= 8'h00;
		end else begin
			event_ready <= !stall && !(event_valid && event_ready);
			if (event_valid && event_ready) begin
				n_taken <= n_taken + 8'h01;
				last_code <= event_code;
			end
		end
	end
endmodule // ipe_fifo_sink

// File: testbench/testbench.sv
// Self-checking bench of the input configuration block.
`timescale 1ns/100ps
module testbench;
	import ipe_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [10:0] pin = 11'h000;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [4:0]  pu_weak;
	logic [4:0]  pd;
	logic [4:0]  pu_strong;
	logic        agg_irq;
	logic        event_valid;
	logic        event_ready;
	logic [7:0]  event_code;
	logic        stall = 1'b0;
	logic [7:0]  n_taken;
	logic [7:0]  last_code;
	logic        evt_irq;
	logic [7:0]  n_irq = 8'h00;
	logic [7:0]  v;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	ipe_input_config u_dut (.clk(clk), .rst(rst), .general_input_pin(pin),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .column_pullup_weak(pu_weak), .column_pulldown(pd),
		.column_pullup_strong(pu_strong), .aggregate_input_irq(agg_irq),
		.event_valid(event_valid), .event_ready(event_ready), .event_code(event_code),
		.event_irq_set(evt_irq));
	ipe_fifo_sink u_sink (.clk(clk), .rst(rst), .stall(stall), .event_valid(event_valid),
		.event_code(event_code), .event_ready(event_ready), .n_taken(n_taken),
		.last_code(last_code));
	// Clock and the watchdog that cuts a hang short.
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Counts event interrupt pulses, to be held against the entries the sink accepted.
	always @(posedge clk) begin
		if (evt_irq === 1'b1) begin
			n_irq <= n_irq + 8'h01;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Reset values of the pull, polarity and route registers, pull outputs and an unmapped place.
	task automatic t_reset();
		logic [7:0] a [6] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E};
		logic [7:0] e [6] = '{8'h51, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(a[i], v);
			chk(v, e[i]);
		end
		chk({3'h0, pd}, 8'h1D);
		chk({3'h0, pu_weak}, 8'h02);
		chk({3'h0, pu_strong}, 8'h00);
		rd(8'h00, v);
		chk(v, 8'h00);
	endtask
	// Every pull code applied to all columns.
	task automatic t_pull();
		for (int c = 0; c < 4; c++) begin
			wr(8'h19, {4{c[1:0]}});
			wr(8'h1A, {6'h00, c[1:0]});
			w(2);
			chk({3'h0, pu_weak}, {3'h0, {5{c == 0}}});
			chk({3'h0, pd}, {3'h0, {5{c == 1}}});
			chk({3'h0, pu_strong}, {3'h0, {5{c == 2}}});
		end
	endtask
	// Low and high polarity, clear on read and re-arm while active.
	task automatic t_flags();
		rd(8'h13, v);
		chk(v, 8'h3F);
		rd(8'h13, v);
		chk(v, 8'h3F);
		rd(8'h14, v);
		chk(v, 8'h1F);
		wr(8'h1B, 8'h3F);
		wr(8'h1C, 8'h1F);
		rd(8'h13, v);
		rd(8'h13, v);
		chk(v, 8'h00);
		@(posedge clk);
		pin[0] <= 1'b1;
		w(8);
		chk({7'h00, agg_irq}, 8'h00);
		rd(8'h13, v);
		chk(v, 8'h01);
	endtask
	// Enable, then routing, then entries with and without a stalled sink.
	task automatic t_route();
		wr(8'h1F, 8'h01);
		w(4);
		chk({7'h00, agg_irq}, 8'h01);
		wr(8'h1D, 8'h01);
		w(4);
		chk({7'h00, agg_irq}, 8'h00);
		chk(n_taken, 8'h00);
		@(posedge clk);
		pin[0] <= 1'b0;
		w(12);
		chk(n_taken, 8'h01);
		chk(last_code, 8'h25);
		@(posedge clk);
		pin[1] <= 1'b1;
		w(12);
		chk(n_taken, 8'h01);
		wr(8'h1E, 8'h10);
		stall <= 1'b1;
		pin[10] <= 1'b1;
		w(12);
		chk({7'h00, event_valid}, 8'h01);
		stall <= 1'b0;
		w(6);
		chk(n_taken, 8'h02);
		chk(last_code, 8'hAF);
		chk(n_irq, 8'h02);
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		w(10);
		t_reset();
		t_pull();
		t_flags();
		t_route();
		tally_and_finish();
	end
endmodule // testbench
